/* File: hdl/rsis_pkg.sv */
package rsis_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] CAUSE_OFS = 8'h00;
    localparam logic [7:0] OPTION_OFS = 8'h04;
    localparam logic [7:0] STATE_OFS = 8'h08;

    // Reset cause bit positions
    localparam int CAUSE_LVI = 1;
    localparam int CAUSE_MOD = 2;
    localparam int CAUSE_BADADDR = 3;
    localparam int CAUSE_BADOP = 4;
    localparam int CAUSE_WDOG = 5;
    localparam int CAUSE_EXT = 6;
    localparam int CAUSE_POR = 7;
    localparam logic [7:0] CAUSE_RESET = 8'h82;

    // Option register: halt permit bit
    localparam int OPT_HALT_OK = 0;
    localparam logic OPTION_RESET = 1'b0;

    // ----------------------------------------
    // Timing in crystal clock cycles
    // ----------------------------------------
    localparam logic [12:0] STAB_CYC = 13'h1000;
    localparam logic [12:0] PIN_CYC = 13'h0020;
    localparam logic [12:0] HOLD_CYC = 13'h0020;

    // ----------------------------------------
    // Vectors and stacking
    // ----------------------------------------
    localparam logic [15:0] RESET_VEC = 16'hfffe;
    localparam logic [15:0] MONITOR_VEC = 16'hfefe;
    localparam logic [15:0] SOFT_VEC = 16'hfffc;
    localparam logic [15:0] IRQ_VEC_BASE = 16'hfffa;
    localparam int IRQ_NUM = 16;
    localparam logic [15:0] WDOG_CLR_ADDR = 16'hffff;
    // Order: ccr, a, x low, pc high, pc low
    localparam logic [4:0] STACK_SET = 5'h1f;

    typedef enum logic [2:0] {
        S_RUN, S_LVW, S_STAB, S_PIN, S_EXT, S_HOLD
    } rsis_state_t;

endpackage : rsis_pkg

/* File: hdl/rsis_seq.sv */
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Function
// - Any reset aborts current instruction immediately
// - Reset vector FFFE, or FEFE in monitor
// - Every reset selects crystal clock div four
// - External low pin resets, sets external flag
// - Internal reset: pin low 32, hold 32
// - Power-on: gate 4096, release 32, fetch 64
// - Power-on sets power and low-voltage flags only
// - Watchdog overflow resets; write FFFF clears counter
// - Low-voltage: hold pin while low, then delays
// - Illegal opcode resets, sets bad-opcode flag
// - Halt without permit counts as illegal opcode
// - Opcode fetch unmapped resets, sets bad-address flag
// - Data access to unmapped address: no reset
// - Cause register read-only, cleared by read
// - Flags of successive resets accumulate until read
// - Sample pin 32 after release; low sets external
// - Forced monitor entry sets monitor flag
// - Interrupts wait for instruction completion
// - Entry stacks registers, masks, loads vector
// - Latched interrupt never preempted
// - Highest priority pending taken after each instruction
// - Index high byte never stacked
// - Mask blocks all but software interrupt
module rsis_seq #(
    parameter int unsigned WDOG_CYCLES = 262144
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe,
    input wire logic low_supply,
    input wire logic monitor_mode,
    input wire logic monitor_force,
    input wire logic core_wr,
    input wire logic [15:0] core_addr,
    input wire logic core_fetch,
    input wire logic addr_unmapped,
    input wire logic opcode_bad,
    input wire logic halt_exec,
    input wire logic instr_done,
    input wire logic swi_exec,
    input wire logic rti_exec,
    input wire logic rti_mask,
    input wire logic [rsis_pkg::IRQ_NUM-1:0] irq_req,
    output logic core_reset,
    output logic clk_gate,
    output logic clk_div4_sel,
    output logic instr_abort,
    output logic vector_fetch,
    output logic int_enter,
    output logic [4:0] int_stack,
    output logic [15:0] vector_addr,
    output logic imask
);
    import rsis_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    rsis_state_t seq_q, seq_d;
    logic [12:0] cnt_q;
    logic [31:0] wdog_q;
    logic [7:0] cause_q, cause_d;
    logic halt_ok_q;
    logic pin_oe_q, core_reset_q, clk_gate_q, div4_q, abort_q;
    logic vec_fetch_q, int_enter_q, imask_q;
    logic [4:0] int_stack_q;
    logic [15:0] vector_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;

    // Lowest index wins: index 0 is highest priority
    function automatic logic [3:0] rsis_pick(input logic [15:0] req);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = IRQ_NUM - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : rsis_pick

    // ----------------------------------------
    // Reset source decode
    // ----------------------------------------
    wire run = (seq_q == S_RUN);
    wire wdog_ovf = (wdog_q == 32'(WDOG_CYCLES - 1));
    wire wdog_clr = core_wr && (core_addr == WDOG_CLR_ADDR);
    wire halt_bad = halt_exec && !halt_ok_q;
    wire src_badop = core_fetch && (opcode_bad || halt_bad);
    // Only opcode fetches count; data accesses ignored
    wire src_badaddr = core_fetch && addr_unmapped;
    wire src_int = wdog_ovf || src_badop || src_badaddr || monitor_force;
    wire src_ext = !rst_pin_in;
    wire go_reset = run && (low_supply || src_ext || src_int);
    wire cnt_end_stab = (cnt_q == STAB_CYC - 13'h0001);
    wire cnt_end_pin = (cnt_q == PIN_CYC - 13'h0001);
    wire cnt_end_hold = (cnt_q == HOLD_CYC - 13'h0001);
    wire hold_done = (seq_q == S_HOLD) && cnt_end_hold;
    // Pin checked 32 cycles after our release
    wire late_pin = hold_done && !rst_pin_in;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        seq_d = seq_q;
        unique case (seq_q)
            S_RUN: begin
                if (low_supply) begin
                    seq_d = S_LVW;
                end else if (src_ext) begin
                    seq_d = S_EXT;
                end else if (src_int) begin
                    seq_d = S_PIN;
                end
            end
            S_LVW: begin
                if (!low_supply) begin
                    seq_d = S_STAB;
                end
            end
            S_STAB: begin
                if (cnt_end_stab) begin
                    seq_d = S_PIN;
                end
            end
            S_PIN: begin
                if (cnt_end_pin) begin
                    seq_d = S_HOLD;
                end
            end
            S_EXT: begin
                if (rst_pin_in) begin
                    seq_d = S_HOLD;
                end
            end
            S_HOLD: begin
                if (cnt_end_hold) begin
                    seq_d = S_RUN;
                end
            end
        endcase
        // Supply drop restarts the sequence from any state
        if (low_supply) begin
            seq_d = S_LVW;
        end
    end

    // ----------------------------------------
    // Reset cause flags
    // ----------------------------------------
    wire apb_setup = psel && !penable;
    wire apb_done = psel && penable && pready_q;
    wire [7:0] cause_set = {1'b0,
        (run && src_ext && !low_supply) || late_pin,
        run && wdog_ovf,
        run && src_badop,
        run && src_badaddr,
        run && monitor_force,
        low_supply && (seq_q != S_LVW),
        1'b0};
    // Clear only at completion of the read; new events win
    wire cause_clr = apb_done && !pwrite && (paddr == CAUSE_OFS);
    assign cause_d = (cause_clr ? 8'h00 : cause_q) | cause_set;

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    wire hit_cause = (paddr == CAUSE_OFS);
    wire hit_opt = (paddr == OPTION_OFS);
    wire hit_state = (paddr == STATE_OFS);
    wire apb_err = !(hit_cause || hit_opt || hit_state)
        || (pwrite && !hit_opt);
    wire [31:0] rd_mux = hit_cause ? {24'h000000, cause_q}
        : hit_opt ? {31'h00000000, halt_ok_q}
        : hit_state ? {29'h00000000, seq_q}
        : 32'h00000000;
    wire opt_wr = apb_done && pwrite && hit_opt;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
            halt_ok_q <= OPTION_RESET;
            cause_q <= CAUSE_RESET;
        end else begin
            pready_q <= apb_setup;
            pslverr_q <= apb_setup && apb_err;
            prdata_q <= (apb_setup && !pwrite) ? rd_mux : 32'h00000000;
            if (opt_wr) begin
                halt_ok_q <= pwdata[OPT_HALT_OK];
            end
            cause_q <= cause_d;
        end
    end

    // ----------------------------------------
    // Interrupt entry
    // ----------------------------------------
    // Taken only at instruction end, never while resetting
    wire can_take = run && instr_done && !go_reset;
    wire [15:0] irq_pend = irq_req & {IRQ_NUM{!imask_q}};
    wire take_swi = can_take && swi_exec;
    wire take_irq = can_take && !swi_exec && (|irq_pend);
    wire [3:0] irq_idx = rsis_pick(irq_pend);
    wire [15:0] irq_vec = IRQ_VEC_BASE - {11'h000, irq_idx, 1'b0};

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            seq_q <= S_STAB;
            cnt_q <= 13'h0000;
            wdog_q <= 32'h00000000;
            pin_oe_q <= 1'b1;
            core_reset_q <= 1'b1;
            clk_gate_q <= 1'b1;
            div4_q <= 1'b1;
            abort_q <= 1'b0;
            vec_fetch_q <= 1'b0;
            int_enter_q <= 1'b0;
            int_stack_q <= 5'h00;
            vector_q <= RESET_VEC;
            imask_q <= 1'b1;
        end else begin
            seq_q <= seq_d;
            cnt_q <= (seq_d != seq_q) ? 13'h0000 : cnt_q + 13'h0001;
            wdog_q <= (!run || wdog_clr) ? 32'h00000000
                : wdog_q + 32'h00000001;
            pin_oe_q <= (seq_d == S_PIN) || (seq_d == S_STAB)
                || (seq_d == S_LVW);
            core_reset_q <= (seq_d != S_RUN);
            clk_gate_q <= (seq_d == S_STAB);
            abort_q <= go_reset;
            div4_q <= go_reset || (div4_q && !run);
            vec_fetch_q <= hold_done && !low_supply;
            int_enter_q <= take_swi || take_irq;
            // Index high byte deliberately left off the stack
            int_stack_q <= (take_swi || take_irq) ? STACK_SET
                : 5'h00;
            if (hold_done) begin
                vector_q <= monitor_mode ? MONITOR_VEC : RESET_VEC;
            end else if (take_swi) begin
                vector_q <= SOFT_VEC;
            end else if (take_irq) begin
                vector_q <= irq_vec;
            end
            // Mask set at latch, so nothing else can preempt
            if (!run || take_swi || take_irq) begin
                imask_q <= 1'b1;
            end else if (rti_exec && instr_done) begin
                imask_q <= rti_mask;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    // Open drain: only ever pulls low
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe = pin_oe_q;
    assign core_reset = core_reset_q;
    assign clk_gate = clk_gate_q;
    assign clk_div4_sel = div4_q;
    assign instr_abort = abort_q;
    assign vector_fetch = vec_fetch_q;
    assign int_enter = int_enter_q;
    assign int_stack = int_stack_q;
    assign vector_addr = vector_q;
    assign imask = imask_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_abort;
        @(posedge clock) disable iff (rst)
        go_reset |=> instr_abort && clk_div4_sel && core_reset;
    endproperty
    a_abort: assert property (p_abort)
        else $error("reset did not abort instruction");

    property p_vec;
        @(posedge clock) disable iff (rst)
        $rose(vector_fetch) |-> !core_reset && (vector_addr ==
            ($past(monitor_mode) ? MONITOR_VEC : RESET_VEC));
    endproperty
    a_vec: assert property (p_vec)
        else $error("wrong reset vector");

    property p_ext;
        @(posedge clock) disable iff (rst)
        run && !rst_pin_in && !low_supply |=> cause_q[CAUSE_EXT]
            && rst_pin_oe == 1'b0;
    endproperty
    a_ext: assert property (p_ext)
        else $error("external reset not flagged");

    property p_hold;
        @(posedge clock) disable iff (rst || low_supply)
        $fell(rst_pin_oe) |-> core_reset ##31 core_reset ##1 !core_reset;
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold after pin release not 32 cycles");

    property p_gate;
        @(posedge clock) disable iff (rst)
        $fell(clk_gate) |-> $past(cnt_q) == STAB_CYC - 13'h0001
            && rst_pin_oe;
    endproperty
    a_gate: assert property (p_gate)
        else $error("stabilisation delay length wrong");

    property p_wdog;
        @(posedge clock) disable iff (rst)
        run && wdog_ovf |=> cause_q[CAUSE_WDOG] && instr_abort;
    endproperty
    a_wdog: assert property (p_wdog)
        else $error("watchdog overflow not handled");

    property p_halt;
        @(posedge clock) disable iff (rst)
        run && core_fetch && halt_exec && !halt_ok_q
            |=> cause_q[CAUSE_BADOP];
    endproperty
    a_halt: assert property (p_halt)
        else $error("forbidden halt not treated as bad opcode");

    property p_clear;
        @(posedge clock) disable iff (rst)
        cause_clr && cause_set == 8'h00 |=> cause_q == 8'h00;
    endproperty
    a_clear: assert property (p_clear)
        else $error("read did not clear cause flags");

    property p_rdold;
        @(posedge clock) disable iff (rst)
        apb_setup && !pwrite && hit_cause |=> prdata[7:0] == $past(cause_q);
    endproperty
    a_rdold: assert property (p_rdold)
        else $error("cause read returned wrong value");

    property p_mask;
        @(posedge clock) disable iff (rst)
        int_enter |-> imask && $past(instr_done) && int_stack[4];
    endproperty
    a_mask: assert property (p_mask)
        else $error("entry without mask or outside instruction end");

endmodule : rsis_seq

`default_nettype wire

/* File: tb/rsis_pin_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Reset pin wire, pull-up and outside pull-down
// ----------------------------------------
module rsis_pin_model (
    input wire logic rst_pin_oe,
    input wire logic rst_pin_out,
    input wire logic ext_hold,
    output logic pin_level
);
    // Open drain: a released line rises through the pull-up
    assign pin_level = ((rst_pin_oe && !rst_pin_out) || ext_hold) ?
        1'b0 : 1'b1;
endmodule : rsis_pin_model

`default_nettype wire

/* File: tb/rsis_seq_test.sv */
`timescale 1ns/100ps
`default_nettype none

module rsis_seq_test;
    import rsis_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, pin_level, ext_hold = 1'b0;
    logic low_supply = 1'b0, monitor_mode = 1'b0, monitor_force = 1'b0;
    logic core_wr = 1'b0, core_fetch = 1'b0, addr_unmapped = 1'b0;
    logic opcode_bad = 1'b0, halt_exec = 1'b0, instr_done = 1'b0;
    logic swi_exec = 1'b0, rti_exec = 1'b0, rti_mask = 1'b0;
    logic [15:0] core_addr = 16'h0, irq_req = 16'h0, vector_addr, irq;
    logic rst_pin_out, rst_pin_oe, core_reset, clk_gate, clk_div4_sel;
    logic instr_abort, vector_fetch, int_enter, imask;
    logic [4:0] int_stack;
    int failures = 0;
    int check_count = 0;
    int m_cause = 0;
    int k;
    logic [15:0] exp_vec;

    always #4 clock = ~clock;

    // Long enough that no scenario but the watchdog one overflows it
    rsis_seq #(.WDOG_CYCLES(256)) rsis_seq_inst (
        .clock(clock), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rst_pin_in(pin_level), .rst_pin_out(rst_pin_out),
        .rst_pin_oe(rst_pin_oe), .low_supply(low_supply),
        .monitor_mode(monitor_mode), .monitor_force(monitor_force),
        .core_wr(core_wr), .core_addr(core_addr), .core_fetch(core_fetch),
        .addr_unmapped(addr_unmapped), .opcode_bad(opcode_bad),
        .halt_exec(halt_exec), .instr_done(instr_done),
        .swi_exec(swi_exec), .rti_exec(rti_exec), .rti_mask(rti_mask),
        .irq_req(irq_req), .core_reset(core_reset), .clk_gate(clk_gate),
        .clk_div4_sel(clk_div4_sel), .instr_abort(instr_abort),
        .vector_fetch(vector_fetch), .int_enter(int_enter),
        .int_stack(int_stack), .vector_addr(vector_addr), .imask(imask)
    );

    rsis_pin_model rsis_pin_model_inst (
        .rst_pin_oe(rst_pin_oe), .rst_pin_out(rst_pin_out),
        .ext_hold(ext_hold), .pin_level(pin_level)
    );

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic conclude;
        if (failures == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_val

    // Negative expectation skips a count the walk leaves open
    task automatic cmp_cnt(input int got, input int exp);
        if (exp >= 0) cmp_val(32'(got), 32'(exp));
    endtask : cmp_cnt

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never reassigns psel at once
        @(posedge clock);
    endtask : apb

    task automatic read_cause;
        apb(1'b0, CAUSE_OFS, 32'h0);
        cmp_val(rd, 32'(m_cause));
        m_cause = 0;
    endtask : read_cause

    task automatic fetch(input logic bad, input logic halt, input logic unm);
        core_fetch <= 1'b1;
        opcode_bad <= bad;
        halt_exec <= halt;
        addr_unmapped <= unm;
        @(posedge clock);
        core_fetch <= 1'b0;
        opcode_bad <= 1'b0;
        halt_exec <= 1'b0;
        addr_unmapped <= 1'b0;
    endtask : fetch

    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge clock);
            cmp_val({31'h0, core_reset}, 32'h0);
        end
    endtask : quiet

    task automatic step(input logic software_interrupt);
        instr_done <= 1'b1;
        swi_exec <= software_interrupt;
        @(posedge clock);
        instr_done <= 1'b0;
        swi_exec <= 1'b0;
        @(posedge clock);
    endtask : step

    // Follows one reset to its vector fetch, releasing outside holds
    task automatic recover(input int oe_x, input int gate_x, input int ab_x,
                           input logic [15:0] vec, input int n_x,
                           input int rel);
        int n, n_oe, n_gate, n_ab;
        n = 0;
        n_oe = 0;
        n_gate = 0;
        n_ab = 0;
        do begin
            @(posedge clock);
            n++;
            if (n == rel) begin
                ext_hold <= 1'b0;
                low_supply <= 1'b0;
            end
            if (rst_pin_oe === 1'b1) n_oe++;
            if (clk_gate === 1'b1) n_gate++;
            if (instr_abort === 1'b1) begin
                n_ab++;
                cmp_val({31'h0, clk_div4_sel & core_reset}, 32'h1);
            end
        end while (vector_fetch !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            failures++;
            conclude();
        end
        cmp_cnt(n_oe, oe_x);
        cmp_cnt(n_gate, gate_x);
        cmp_cnt(n_ab, ab_x);
        cmp_cnt(n, n_x);
        cmp_val({15'h0, core_reset, vector_addr}, {16'h0, vec});
    endtask : recover

    initial begin
        void'($urandom(32'hbf77));
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        m_cause = 32'(CAUSE_RESET);
        recover(4128, 4096, -1, RESET_VEC, -1, 0);
        read_cause();
        apb(1'b0, STATE_OFS, 32'h0);
        cmp_val(rd, 32'(S_RUN));
        cmp_val({31'h0, er}, 32'h0);
        apb(1'b1, CAUSE_OFS, $urandom);
        cmp_val({31'h0, er}, 32'h1);
        apb(1'b1, 8'h0c, 32'h0);
        cmp_val({31'h0, er}, 32'h1);
        read_cause();
        fetch(1'b1, 1'b0, 1'b0);
        m_cause = 1 << CAUSE_BADOP;
        recover(32, 0, 1, RESET_VEC, 65, 0);
        read_cause();
        fetch(1'b0, 1'b1, 1'b0);
        m_cause = 1 << CAUSE_BADOP;
        recover(32, 0, 1, RESET_VEC, 65, 0);
        read_cause();
        apb(1'b1, OPTION_OFS, 32'h1);
        apb(1'b0, OPTION_OFS, 32'h0);
        cmp_val(rd, 32'h1);
        fetch(1'b0, 1'b1, 1'b0);
        quiet(80);
        apb(1'b1, OPTION_OFS, 32'h0);
        addr_unmapped <= 1'b1;
        quiet(5);
        fetch(1'b0, 1'b0, 1'b1);
        recover(32, 0, 1, RESET_VEC, 65, 0);
        fetch(1'b1, 1'b0, 1'b0);
        recover(32, 0, 1, RESET_VEC, 65, 0);
        m_cause = (1 << CAUSE_BADOP) | (1 << CAUSE_BADADDR);
        read_cause();
        monitor_mode <= 1'b1;
        monitor_force <= 1'b1;
        @(posedge clock);
        monitor_force <= 1'b0;
        recover(32, 0, 1, MONITOR_VEC, 65, 0);
        monitor_mode <= 1'b0;
        m_cause = 1 << CAUSE_MOD;
        read_cause();
        fetch(1'b1, 1'b0, 1'b0);
        ext_hold <= 1'b1;
        recover(32, 0, 1, RESET_VEC, 65, 64);
        m_cause = (1 << CAUSE_BADOP) | (1 << CAUSE_EXT);
        read_cause();
        repeat (4) begin
            quiet(200);
            core_wr <= 1'b1;
            core_addr <= WDOG_CLR_ADDR;
            @(posedge clock);
            core_wr <= 1'b0;
            core_addr <= 16'($urandom);
        end
        recover(32, 0, 1, RESET_VEC, -1, 0);
        m_cause = 1 << CAUSE_WDOG;
        read_cause();
        ext_hold <= 1'b1;
        recover(0, 0, 1, RESET_VEC, -1, 10);
        m_cause = 1 << CAUSE_EXT;
        read_cause();
        low_supply <= 1'b1;
        recover(-1, 4096, 1, RESET_VEC, -1, 20);
        m_cause = 1 << CAUSE_LVI;
        read_cause();
        repeat (8) begin
            rti_exec <= 1'b1;
            step(1'b0);
            rti_exec <= 1'b0;
            cmp_val({31'h0, imask}, 32'h0);
            irq = 16'($urandom);
            if (irq == 16'h0) irq = 16'h8000;
            irq_req <= irq;
            repeat (2) @(posedge clock);
            cmp_val({31'h0, int_enter}, 32'h0);
            step(1'b0);
            for (k = 15; k >= 0; k--) if (irq[k]) break;
            for (k = 0; k < 16; k++) if (irq[k]) break;
            exp_vec = IRQ_VEC_BASE - 16'(2 * k);
            cmp_val({int_enter, imask, 9'h0, int_stack, vector_addr},
                {2'b11, 9'h0, STACK_SET, exp_vec});
            step(1'b0);
            cmp_val({31'h0, int_enter}, 32'h0);
            step(1'b1);
            cmp_val({int_enter, 15'h0, vector_addr},
                {16'h8000, SOFT_VEC});
            irq_req <= 16'h0;
        end
        conclude();
    end
endmodule : rsis_seq_test

`default_nettype wire
